// file: logic/rmc_config_regs.sv
// Purpose: modem configuration and status register bank on Avalon-MM
// Assumes: 32-bit bus words, registers in bits 7:0, byte address = 4 x index
// Notes:   settings are latched at operation start so mid-frame writes wait
//
// What this block does
// R1: each random byte read advances the pseudorandom register thirteen steps
// R2: random byte register is read-only, eight bits, zero after reset
// R3: decay field selects cost increment 8, 16, 32 or 64
// R4: tone bit 0 modulates at the tone IF, 1 outputs tone only
// R5: four-bit modulation field, seven defined codes, reset 0010, others reserved
// R6: phase bit 0 maps zero to negative deviation, one to positive
// R7: phase bit 1 maps zero to positive deviation, one to negative
// R8: compensation mode off, freeze after sync, continuous, or freeze with double decay
// R9: five-bit correlator threshold resets to 0x0F, used for sync search
// R10: bit order 0 sends sync word bit 0 first, receive expects same
// R11: bit order 1 sends sync word bit 31 first, receive expects same
// R12: preamble mode bit picks pattern or its complement for offset estimation
// R13: preamble select 00 makes last preamble bit inverse of first sync bit
// R14: preamble select 01 makes last preamble bit equal first sync bit
// R15: preamble select 10 gives 0x55, 11 gives 0xAA
// R16: preamble bytes sent equal the count field plus one
// R17: sync length 0 means 32 bits, 1xxxx means 16 to 31, rest reserved
// R18: primary sync word is 32 bits in four byte registers, top byte highest
// R19: reserved bits read zero; settings sampled at each operation start
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
module rmc_config_regs
(
    input  wire logic                            CLK,
    input  wire logic                            RST,
    input  wire logic                   [17:0]   AVS_ADDRESS,
    input  wire logic                            AVS_READ,
    input  wire logic                            AVS_WRITE,
    input  wire logic                   [3:0]    AVS_BYTEENABLE,
    input  wire logic                   [31:0]   AVS_WRITEDATA,
    output logic                        [31:0]   AVS_READDATA,
    output logic                                 AVS_WAITREQUEST,
    output logic                        [1:0]    AVS_RESPONSE,
    output rmc_pkg::rmc_modem_setting_type       MODEM_SETTING,
    output logic                        [31:0]   SYNC_WORD,
    output logic                                 OP_ACTIVE
);
    // ************************************************************
    // storage
    // ************************************************************
    rmc_pkg::rmc_cfg0_type cfg0_reg;
    rmc_pkg::rmc_cfg1_type cfg1_reg;
    rmc_pkg::rmc_cfg2_type cfg2_reg;
    logic [7:0]  sync_cfg_reg;
    logic [7:0]  sync_byte_reg [0:3];
    logic        ack_reg;
    logic        op_active_reg;

    // ************************************************************
    // decode
    // ************************************************************
    wire  [15:0] idx        = AVS_ADDRESS[17:2];
    wire         req        = (AVS_READ | AVS_WRITE) & ~ack_reg;
    wire         wr_en      = AVS_WRITE & ack_reg & AVS_BYTEENABLE[0];
    wire         rd_done    = AVS_READ & ack_reg;
    wire         hit_rand   = idx == rmc_pkg::RANDOM_BYTE_OUT_IDX;
    wire         hit_cfg0   = idx == rmc_pkg::MODEM_CONFIG_0_IDX;
    wire         hit_cfg1   = idx == rmc_pkg::MODEM_CONFIG_1_IDX;
    wire         hit_cfg2   = idx == rmc_pkg::MODEM_CONFIG_2_IDX;
    wire         hit_swcfg  = idx == rmc_pkg::SYNC_CONFIG_IDX;
    wire         hit_op     = idx == rmc_pkg::OP_CONTROL_IDX;
    wire         hit_sw     = (idx >= rmc_pkg::SYNC_WORD_0_IDX) &&
                              (idx <= rmc_pkg::SYNC_WORD_3_IDX);
    wire  [1:0]  sw_sel     = 2'(idx - rmc_pkg::SYNC_WORD_0_IDX);
    wire         mapped     = hit_rand | hit_cfg0 | hit_cfg1 | hit_cfg2 | hit_swcfg
                              | hit_op | hit_sw;
    wire  [7:0]  wdata      = AVS_WRITEDATA[7:0];
    wire         op_start   = wr_en & hit_op & wdata[0];
    wire         op_stop    = wr_en & hit_op & ~wdata[0];
    wire  [31:0] sync_word  = {sync_byte_reg[3], sync_byte_reg[2],
                               sync_byte_reg[1], sync_byte_reg[0]};               // R18
    wire         first_bit  = cfg2_reg.sync_bit_order ? sync_word[31] : sync_word[0];
    wire  [7:0]  random_byte;
    rmc_pkg::rmc_modem_setting_type decoded;

    // ************************************************************
    // read mux
    // ************************************************************
    wire  [7:0]  rd_byte =
        hit_rand  ? random_byte :                                                // R2
        hit_cfg0  ? cfg0_reg :
        hit_cfg1  ? (cfg1_reg & rmc_pkg::CFG1_MASK) :                          // R19
        hit_cfg2  ? cfg2_reg :
        hit_swcfg ? (sync_cfg_reg & rmc_pkg::SYNC_CFG_MASK) :
        hit_op    ? {7'h00, op_active_reg} :
        hit_sw    ? sync_byte_reg[sw_sel] : 8'h00;

    rmc_random_source #(
        .STEPS             (rmc_pkg::LFSR_STEPS)
    ) u_random (
        .CLK               (CLK),
        .RST               (RST),
        .read_pulse        (rd_done & hit_rand),
        .random_byte_value (random_byte)
    );

    rmc_setting_decode u_decode (
        .cfg0                (cfg0_reg),
        .cfg1                (cfg1_reg),
        .cfg2                (cfg2_reg),
        .sync_length_setting (sync_cfg_reg[4:0]),
        .first_sync_bit      (first_bit),
        .setting             (decoded)
    );

    // ************************************************************
    // bus handshake: one wait cycle, then answer
    // ************************************************************
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ack_reg         <= 1'b0;
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= 32'h0000_0000;
            AVS_RESPONSE    <= 2'h0;
        end
        else
        begin
            ack_reg         <= req;
            AVS_WAITREQUEST <= ~req;
            AVS_READDATA    <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            AVS_RESPONSE    <= (req & ~mapped) ? 2'h2 : 2'h0;
        end
    end

    // ************************************************************
    // configuration writes
    // ************************************************************
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            cfg0_reg     <= rmc_pkg::CFG0_RESET;                                  // R5
            cfg1_reg     <= rmc_pkg::CFG1_RESET;                                  // R9
            cfg2_reg     <= rmc_pkg::CFG2_RESET;
            sync_cfg_reg <= rmc_pkg::SYNC_CFG_RESET;
        end
        else if (wr_en)
        begin
            if (hit_cfg0)
                cfg0_reg <= wdata & rmc_pkg::CFG0_MASK;
            if (hit_cfg1)
                cfg1_reg <= wdata & rmc_pkg::CFG1_MASK;                           // R19
            if (hit_cfg2)
                cfg2_reg <= wdata;
            if (hit_swcfg)
                sync_cfg_reg <= wdata & rmc_pkg::SYNC_CFG_MASK;
        end
    end

    genvar b;
    generate
        for (b = 0; b < 4; b++)
        begin : g_sw
            always_ff @(posedge CLK)
            begin
                if (RST)
                    sync_byte_reg[b] <= 8'h00;
                else if (wr_en && hit_sw && sw_sel == 2'(b))
                    sync_byte_reg[b] <= wdata;                                    // R18
            end
        end
    endgenerate

    // ************************************************************
    // operation snapshot: datapath sees stable values per frame
    // ************************************************************
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            op_active_reg <= 1'b0;
            OP_ACTIVE     <= 1'b0;
            MODEM_SETTING <= '0;
            SYNC_WORD     <= 32'h0000_0000;
        end
        else
        begin
            if (op_start)
                op_active_reg <= 1'b1;
            else if (op_stop)
                op_active_reg <= 1'b0;
            OP_ACTIVE <= op_start | (op_active_reg & ~op_stop);
            if (op_start)
            begin
                MODEM_SETTING <= decoded;                                         // R19
                SYNC_WORD     <= sync_word;
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    sequence rand_read_s;
        AVS_READ && ack_reg && hit_rand;
    endsequence

    random_advance_a: assert property (@(posedge CLK) disable iff (RST) // R1
        rand_read_s |=> (random_byte != $past(random_byte)) || (random_byte == 8'h00))
        else $error("random byte did not advance");
    random_reset_a: assert property (@(posedge CLK) // R2
        $past(RST) |-> random_byte == 8'h00)
        else $error("random byte not zero after reset");
    decay_value_a: assert property (@(posedge CLK) disable iff (RST) // R3
        op_start |=> MODEM_SETTING.decay_increment == (8'h08 << $past(cfg0_reg.offset_comp_decay)))
        else $error("decay increment wrong");
    modulation_reset_a: assert property (@(posedge CLK) // R5
        $past(RST) |-> cfg0_reg.modulation == 4'h2)
        else $error("modulation reset wrong");
    threshold_reset_a: assert property (@(posedge CLK) // R9
        $past(RST) |-> cfg1_reg.correlator_threshold == 5'h0F)
        else $error("threshold reset wrong");
    phase_snapshot_a: assert property (@(posedge CLK) disable iff (RST) // R6
        op_start |=> MODEM_SETTING.phase_invert == $past(cfg0_reg.phase_invert))
        else $error("phase mapping not captured");
    preamble_count_a: assert property (@(posedge CLK) disable iff (RST) // R16
        op_start |=> MODEM_SETTING.preamble_bytes_total
                     == {1'b0, $past(cfg2_reg.preamble_byte_count)} + 5'h01)
        else $error("preamble count wrong");
    fixed_preamble_a: assert property (@(posedge CLK) disable iff (RST) // R15
        cfg2_reg.preamble_pattern_select == 2'h3 |-> decoded.preamble_byte == 8'hAA)
        else $error("fixed preamble wrong");
    reserved_zero_a: assert property (@(posedge CLK) disable iff (RST) // R19
        req && AVS_READ && hit_cfg1 |=> AVS_READDATA[5] == 1'b0)
        else $error("reserved bit read nonzero");
    sync_hold_a: assert property (@(posedge CLK) disable iff (RST) // R19
        !op_start |=> SYNC_WORD == $past(SYNC_WORD))
        else $error("sync word changed outside start");
endmodule : rmc_config_regs

// file: logic/rmc_pkg.sv
// Purpose: shared constants and types for the radio modem configuration bank
// Assumes: 8-bit registers in 32-bit bus words, byte address = 4 x index
// Notes:   offsets are register indices
package rmc_pkg;

    // ************************************************************
    // register indices
    // ************************************************************
    localparam logic [15:0] RANDOM_BYTE_OUT_IDX = 16'h618F;
    localparam logic [15:0] MODEM_CONFIG_0_IDX  = 16'h6190;
    localparam logic [15:0] MODEM_CONFIG_1_IDX  = 16'h6191;
    localparam logic [15:0] MODEM_CONFIG_2_IDX  = 16'h6192;
    localparam logic [15:0] SYNC_CONFIG_IDX     = 16'h6194;
    localparam logic [15:0] SYNC_WORD_0_IDX     = 16'h6195;
    localparam logic [15:0] SYNC_WORD_3_IDX     = 16'h6198;
    localparam logic [15:0] OP_CONTROL_IDX      = 16'h61A0;

    // ************************************************************
    // reset values and field positions
    // ************************************************************
    localparam logic [7:0]  CFG0_RESET     = 8'h04;
    localparam logic [7:0]  CFG1_RESET     = 8'h4F;
    localparam logic [7:0]  CFG2_RESET     = 8'h00;
    localparam logic [7:0]  SYNC_CFG_RESET = 8'h00;
    localparam logic [7:0]  CFG0_MASK      = 8'hFF;
    localparam logic [7:0]  CFG1_MASK      = 8'hDF;
    localparam logic [7:0]  SYNC_CFG_MASK  = 8'h1F;
    localparam logic [7:0]  RANDOM_RESET   = 8'h00;
    localparam logic [15:0] LFSR_SEED      = 16'hACE1;
    localparam logic [15:0] LFSR_TAPS      = 16'hB400;
    localparam int          LFSR_STEPS     = 13;
    localparam int          SYNC_FULL_LEN  = 32;
    localparam logic [7:0]  PREAMBLE_10    = 8'h55;
    localparam logic [7:0]  PREAMBLE_11    = 8'hAA;
    localparam logic [1:0]  PSEL_INV_FIRST = 2'h0;
    localparam logic [1:0]  PSEL_EQ_FIRST  = 2'h1;
    localparam logic [1:0]  PSEL_FIX_55    = 2'h2;
    localparam logic [1:0]  OCB_OFF        = 2'h0;
    localparam logic [1:0]  OCB_DOUBLE     = 2'h3;

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic [1:0] offset_comp_decay;
        logic       tone_only;
        logic [3:0] modulation;
        logic       phase_invert;
    } rmc_cfg0_type;

    typedef struct packed {
        logic [1:0] offset_comp_behaviour;
        logic       reserved;
        logic [4:0] correlator_threshold;
    } rmc_cfg1_type;

    typedef struct packed {
        logic       sync_bit_order;
        logic       preamble_complement_select;
        logic [1:0] preamble_pattern_select;
        logic [3:0] preamble_byte_count;
    } rmc_cfg2_type;

    typedef struct packed {
        logic [7:0] decay_increment;
        logic       comp_enable;
        logic       freeze_after_sync;
        logic       double_decay;
        logic       modulation_valid;
        logic [1:0] deviation_level;
        logic [4:0] correlator_threshold;
        logic [5:0] sync_bits_used;
        logic       sync_length_valid;
        logic       sync_msb_first;
        logic [7:0] preamble_byte;
        logic [7:0] estimator_pattern;
        logic [4:0] preamble_bytes_total;
        logic       tone_only;
        logic       phase_invert;
    } rmc_modem_setting_type;

endpackage : rmc_pkg

// file: logic/rmc_random_source.sv
// Purpose: pseudorandom byte source advanced on each read
// Assumes: read_pulse is one cycle per completed bus read
// Notes:   advances the whole step count in one clock
`timescale 1ns/1ps
module rmc_random_source
#(
    parameter int STEPS = rmc_pkg::LFSR_STEPS
)
(
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic       read_pulse,
    output logic      [7:0] random_byte_value
);
    logic [15:0] lfsr_reg;
    logic [15:0] lfsr_next;
    logic [15:0] chain [0:STEPS];

    assign chain[0] = lfsr_reg;
    genvar g;
    generate
        for (g = 0; g < STEPS; g++)
        begin : g_step
            assign chain[g+1] = chain[g][0] ? ((chain[g] >> 1) ^ rmc_pkg::LFSR_TAPS)
                                            : (chain[g] >> 1);
        end
    endgenerate
    assign lfsr_next = read_pulse ? chain[STEPS] : lfsr_reg;

    // value shown after reset is zero, the seed only feeds later reads
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            lfsr_reg          <= rmc_pkg::LFSR_SEED;
            random_byte_value <= rmc_pkg::RANDOM_RESET;
        end
        else if (read_pulse)
        begin
            lfsr_reg          <= lfsr_next;                            // R1
            random_byte_value <= lfsr_next[7:0];
        end
    end
endmodule : rmc_random_source

// file: logic/rmc_setting_decode.sv
// Purpose: decode register fields into the settings the modem datapath uses
// Assumes: purely combinational
// Notes:   reserved codes flag invalid rather than guessing a mode
`timescale 1ns/1ps
module rmc_setting_decode
(
    input  wire rmc_pkg::rmc_cfg0_type          cfg0,
    input  wire rmc_pkg::rmc_cfg1_type          cfg1,
    input  wire rmc_pkg::rmc_cfg2_type          cfg2,
    input  wire logic                  [4:0]    sync_length_setting,
    input  wire logic                           first_sync_bit,
    output rmc_pkg::rmc_modem_setting_type      setting
);
    logic [7:0] pattern;
    logic       last_bit;

    // last preamble bit lands right before the first sync bit
    assign last_bit = (cfg2.preamble_pattern_select == rmc_pkg::PSEL_INV_FIRST)
                      ? ~first_sync_bit : first_sync_bit;                       // R13 R14
    assign pattern  = (cfg2.preamble_pattern_select == rmc_pkg::PSEL_FIX_55) ? rmc_pkg::PREAMBLE_10
                    : (cfg2.preamble_pattern_select[1]) ? rmc_pkg::PREAMBLE_11  // R15
                    : (last_bit ? rmc_pkg::PREAMBLE_11 : rmc_pkg::PREAMBLE_10);

    always_comb
    begin
        setting.decay_increment = 8'h08 << cfg0.offset_comp_decay;              // R3
        setting.comp_enable = cfg1.offset_comp_behaviour != rmc_pkg::OCB_OFF;     // R8
        setting.freeze_after_sync = cfg1.offset_comp_behaviour[0];
        setting.double_decay = cfg1.offset_comp_behaviour == rmc_pkg::OCB_DOUBLE;
        case (cfg0.modulation)                                                  // R5
            4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9: setting.modulation_valid = 1'b1;
            default: setting.modulation_valid = 1'b0;
        endcase
        setting.deviation_level = cfg0.modulation[1:0];
        setting.correlator_threshold = cfg1.correlator_threshold;               // R9
        setting.sync_length_valid = (sync_length_setting == 5'h00) || sync_length_setting[4];
        setting.sync_bits_used = sync_length_setting[4] ? {2'h0, sync_length_setting[3:0]} + 6'h10
                                                       : 6'h20;                 // R17
        setting.sync_msb_first = cfg2.sync_bit_order;                           // R10 R11
        setting.preamble_byte = pattern;
        setting.estimator_pattern = cfg2.preamble_complement_select ? ~pattern : pattern; // R12
        setting.preamble_bytes_total = {1'b0, cfg2.preamble_byte_count} + 5'h01; // R16
        setting.tone_only = cfg0.tone_only;                                     // R4
        setting.phase_invert = cfg0.phase_invert;                               // R6 R7
    end
endmodule : rmc_setting_decode

// file: tb/rmc_config_regs_tb.sv
// Purpose: self-checking bench for the radio modem configuration register bank
// Assumes: Avalon-MM master driven at the rising edge, settings seen after op start
// Notes:   the pseudorandom byte is checked for zero after reset, then only for change, not for exact value
`timescale 1ns/1ps
module rmc_config_regs_tb;
    logic                           CLK;
    logic                           RST;
    logic                   [17:0]  AVS_ADDRESS;
    logic                           AVS_READ;
    logic                           AVS_WRITE;
    logic                   [3:0]   AVS_BYTEENABLE;
    logic                   [31:0]  AVS_WRITEDATA;
    logic                   [31:0]  AVS_READDATA;
    logic                           AVS_WAITREQUEST;
    logic                   [1:0]   AVS_RESPONSE;
    rmc_pkg::rmc_modem_setting_type MODEM_SETTING;
    logic                   [31:0]  SYNC_WORD;
    logic                           OP_ACTIVE;
    int                             fail_count;
    int                             n_tests;
    logic                   [31:0]  q;
    logic                   [31:0]  q2;
    logic                   [1:0]   r;
    logic                   [7:0]   c0;
    logic                   [7:0]   c1;
    logic                   [7:0]   c2;
    logic                   [4:0]   sl;
    logic                   [31:0]  sw;
    logic                   [7:0]   pat;

    rmc_config_regs dut (.CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .AVS_RESPONSE(AVS_RESPONSE), .MODEM_SETTING(MODEM_SETTING), .SYNC_WORD(SYNC_WORD),
        .OP_ACTIVE(OP_ACTIVE));

    always #50 CLK = ~CLK;

    // ************************************************************
    // bus access and checking
    // ************************************************************
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // request held until waitrequest is seen low; one idle edge keeps drivers apart
    task automatic bus(input logic wr_n, input logic [15:0] idx, input logic [7:0] d,
                       input logic [3:0] be, output logic [31:0] dq, output logic [1:0] rs);
        int k;
        AVS_ADDRESS    <= {idx, 2'h0};
        AVS_READ       <= wr_n;
        AVS_WRITE      <= ~wr_n;
        AVS_BYTEENABLE <= be;
        AVS_WRITEDATA  <= {24'h000000, d};
        for (k = 0; k < 50; k++)
        begin
            @(posedge CLK);
            if (AVS_WAITREQUEST === 1'b0)
                break;
        end
        if (k == 50)
        begin
            fail_count++;
            finish_test();
        end
        dq = AVS_READDATA;
        rs = AVS_RESPONSE;
        AVS_READ  <= 1'b0;
        AVS_WRITE <= 1'b0;
        @(posedge CLK);
    endtask : bus

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] dq;
        logic [1:0]  rs;
        bus(1'b0, idx, d, 4'hF, dq, rs);
    endtask : wr

    task automatic rd(input logic [15:0] idx, output logic [31:0] dq);
        logic [1:0] rs;
        bus(1'b1, idx, 8'h00, 4'hF, dq, rs);
    endtask : rd

    // restart so the snapshot is taken from the current register contents
    task automatic start_op();
        int k;
        wr(rmc_pkg::OP_CONTROL_IDX, 8'h00);
        wr(rmc_pkg::OP_CONTROL_IDX, 8'h01);
        for (k = 0; k < 20 && OP_ACTIVE !== 1'b1; k++)
            @(posedge CLK);
        if (k == 20)
        begin
            fail_count++;
            finish_test();
        end
        @(posedge CLK);
    endtask : start_op

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        CLK = 1'b0; RST = 1'b1; AVS_ADDRESS = 18'h00000; AVS_READ = 1'b0; AVS_WRITE = 1'b0;
        AVS_BYTEENABLE = 4'h0; AVS_WRITEDATA = 32'h00000000; fail_count = 0; n_tests = 0;
        repeat (20) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);

        rd(rmc_pkg::MODEM_CONFIG_0_IDX, q);  chk("cfg0 reset", 32'h00000004, q);
        rd(rmc_pkg::MODEM_CONFIG_1_IDX, q);  chk("cfg1 reset", 32'h0000004F, q);
        rd(rmc_pkg::MODEM_CONFIG_2_IDX, q);  chk("cfg2 reset", 32'h00000000, q);
        rd(rmc_pkg::SYNC_CONFIG_IDX, q);     chk("sync cfg reset", 32'h00000000, q);
        rd(rmc_pkg::RANDOM_BYTE_OUT_IDX, q); chk("random reset", 32'h00000000, q);
        $display("test reset values done");

        rd(rmc_pkg::RANDOM_BYTE_OUT_IDX, q);
        wr(rmc_pkg::RANDOM_BYTE_OUT_IDX, q[7:0]);
        rd(rmc_pkg::RANDOM_BYTE_OUT_IDX, q2);
        chk("random advances", 32'h00000001, {31'h0, q !== q2});
        chk("random upper zero", 32'h00000000, {q2[31:8], 8'h00});
        $display("test random source done");

        wr(rmc_pkg::MODEM_CONFIG_1_IDX, 8'hFF);
        rd(rmc_pkg::MODEM_CONFIG_1_IDX, q); chk("cfg1 reserved", 32'h000000DF, q);
        wr(rmc_pkg::SYNC_CONFIG_IDX, 8'hFF);
        rd(rmc_pkg::SYNC_CONFIG_IDX, q);    chk("sync cfg reserved", 32'h0000001F, q);
        bus(1'b1, 16'h6193, 8'h00, 4'hF, q, r);
        chk("unmapped data", 32'h00000000, q);
        chk("unmapped response", 32'h00000002, {30'h0, r});
        bus(1'b0, rmc_pkg::MODEM_CONFIG_2_IDX, 8'h5A, 4'hE, q, r);
        rd(rmc_pkg::MODEM_CONFIG_2_IDX, q); chk("lane0 disabled", 32'h00000000, q);
        $display("test access kinds done");

        for (int i = 0; i < 16; i++)
        begin
            c0 = {i[1:0], i[0], i[3:0], i[1]};
            c1 = {i[2:1], 1'b0, i[3:0], i[0]};
            c2 = {i[0], i[1], i[2:1], i[3:0]};
            sl = (i < 8) ? {2'h0, i[2:0]} : {1'b1, i[3:0]};
            sw = {8'h44, 8'h33, 8'h22, 8'h11} ^ {4{i[7:0]}};
            wr(rmc_pkg::MODEM_CONFIG_0_IDX, c0);
            wr(rmc_pkg::MODEM_CONFIG_1_IDX, c1);
            wr(rmc_pkg::MODEM_CONFIG_2_IDX, c2);
            wr(rmc_pkg::SYNC_CONFIG_IDX, {3'h0, sl});
            for (int b = 0; b < 4; b++)
                wr(rmc_pkg::SYNC_WORD_0_IDX + 16'(b), sw[8*b +: 8]);
            rd(rmc_pkg::MODEM_CONFIG_0_IDX, q); chk("cfg0 readback", {24'h0, c0}, q);
            start_op();
            chk("decay", 32'd8 << c0[7:6], {24'h0, MODEM_SETTING.decay_increment});
            chk("tone", {31'h0, c0[5]}, {31'h0, MODEM_SETTING.tone_only});
            chk("mod valid", {31'h0, c0[4:1] inside {2, 3, 4, 6, 7, 8, 9}},
                {31'h0, MODEM_SETTING.modulation_valid});
            chk("phase", {31'h0, c0[0]}, {31'h0, MODEM_SETTING.phase_invert});
            chk("comp mode", {29'h0, c1[7:6] != 2'h0, c1[6], c1[7:6] == 2'h3},
                {29'h0, MODEM_SETTING.comp_enable, MODEM_SETTING.freeze_after_sync,
                 MODEM_SETTING.double_decay});
            chk("threshold", {27'h0, c1[4:0]}, {27'h0, MODEM_SETTING.correlator_threshold});
            chk("bit order", {31'h0, c2[7]}, {31'h0, MODEM_SETTING.sync_msb_first});
            chk("preamble count", c2[3:0] + 32'd1, {27'h0, MODEM_SETTING.preamble_bytes_total});
            // codes 00/01: bit 7 is the last preamble bit, tied to the first sync bit
            pat = ((c2[7] ? sw[31] : sw[0]) ^ ~c2[4]) ? 8'hAA : 8'h55;
            if (c2[5])
                pat = c2[4] ? 8'hAA : 8'h55;
            chk("preamble", {24'h0, pat}, {24'h0, MODEM_SETTING.preamble_byte});
            chk("estimator", {24'h0, c2[6] ? ~pat : pat},
                {24'h0, MODEM_SETTING.estimator_pattern});
            chk("sync len valid", {31'h0, sl == 5'h00 || sl[4]},
                {31'h0, MODEM_SETTING.sync_length_valid});
            if (sl == 5'h00 || sl[4])
                chk("sync bits", (sl == 5'h00) ? 32'd32 : 32'd16 + sl[3:0],
                    {26'h0, MODEM_SETTING.sync_bits_used});
            chk("sync word", sw, SYNC_WORD);
        end
        $display("test settings table done");

        q = {24'h0, MODEM_SETTING.preamble_byte};
        wr(rmc_pkg::MODEM_CONFIG_2_IDX, 8'h20);
        wr(rmc_pkg::MODEM_CONFIG_0_IDX, 8'h00);
        repeat (3) @(posedge CLK);
        chk("held preamble", q, {24'h0, MODEM_SETTING.preamble_byte});
        chk("held decay", 32'd64, {24'h0, MODEM_SETTING.decay_increment});
        start_op();
        chk("new preamble", 32'h00000055, {24'h0, MODEM_SETTING.preamble_byte});
        chk("new decay", 32'd8, {24'h0, MODEM_SETTING.decay_increment});
        $display("test snapshot done");
        finish_test();
    end
endmodule : rmc_config_regs_tb
